// *** regmap_params.svh ***
`ifndef REGMAP_PARAMS_SVH
`define REGMAP_PARAMS_SVH

// integer windows: first address, last address, storage base
`define INT0_LO      16'h0fa0
`define INT0_HI      16'h101f
`define INT0_BASE    9'h000
`define INT1_LO      16'h10cc
`define INT1_HI      16'h10e0
`define INT1_BASE    9'h080
`define INT2_LO      16'h1130
`define INT2_HI      16'h1158
`define INT2_BASE    9'h095
`define INT3_LO      16'h1194
`define INT3_HI      16'h129d
`define INT3_BASE    9'h0be
`define INT_WORDS    456

// whole float windows
`define FRO_LO       16'h1d4c
`define FRO_HI       16'h1d5f
`define FRO_BASE     9'h000
`define FRW_LO       16'h1db0
`define FRW_HI       16'h1df4
`define FRW_BASE     9'h014
`define FNV_LO       16'h1f40
`define FNV_HI       16'h1f71
`define FNV_BASE     9'h059
`define FLT_WORDS    139

// mirrored float windows, two 16-bit registers per float
`define MRO_LO       16'h1b58
`define MRO_HI       16'h1b7e
`define MRW_LO       16'h1c20
`define MRW_HI       16'h1c9e
`define MNV_LO       16'h1ce8
`define MNV_HI       16'h1d19

// input kind select register location in integer storage
`define KIND_SEL_IDX 9'h000

// function codes
`define FN_RD_GRP    8'h03
`define FN_WR_ONE    8'h06
`define FN_WR_GRP    8'h10
`define FN_IDENT     8'h11

// exception answers
`define EXC_OK       8'h00
`define EXC_ILL_FN   8'h01
`define EXC_ILL_ADDR 8'h02
`define EXC_ILL_VAL  8'h03
`define EXC_FAIL     8'h04

// identification run status byte
`define ID_RUN_STAT  8'hff

// answer deadlines
`define RESP_TIME_MS  100
`define SAVE_TIME_MS  500
`define CLK_PERIOD_NS 10
`define NS_PER_MS     1000000

`endif

// *** regmap_pkg.sv ***
package regmap_pkg;

   // what an address decodes to
   typedef enum logic [1:0] {
      K_NONE,
      K_INT,
      K_FLT,
      K_MIR
   } kind_t;

   // request sequencer states
   typedef enum logic [1:0] {
      S_IDLE,
      S_CHECK,
      S_XFER,
      S_DONE
   } state_t;

endpackage

// *** regmap_addr_decode.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "regmap_params.svh"

module regmap_addr_decode (
   input  wire logic [15:0]       i_addr,
   output regmap_pkg::kind_t      o_kind,
   output logic [8:0]             o_idx,
   output logic                   o_hi_half,
   output logic                   o_writable
);
   import regmap_pkg::*;

   // window lookup, integer and float kept apart
   always_comb begin
      logic [15:0] off;
      off        = 16'h0000;
      o_kind     = K_NONE;
      o_idx      = 9'h000;
      o_hi_half  = 1'b0;
      o_writable = 1'b0;
      if (i_addr >= `INT0_LO && i_addr <= `INT0_HI) begin
         o_kind = K_INT;
         o_idx  = 9'(i_addr - `INT0_LO) + `INT0_BASE;
         o_writable = 1'b1;
      end else if (i_addr >= `INT1_LO && i_addr <= `INT1_HI) begin
         o_kind = K_INT;
         o_idx  = 9'(i_addr - `INT1_LO) + `INT1_BASE;
         o_writable = 1'b1;
      end else if (i_addr >= `INT2_LO && i_addr <= `INT2_HI) begin
         o_kind = K_INT;
         o_idx  = 9'(i_addr - `INT2_LO) + `INT2_BASE;
         o_writable = 1'b1;
      end else if (i_addr >= `INT3_LO && i_addr <= `INT3_HI) begin
         o_kind = K_INT;
         o_idx  = 9'(i_addr - `INT3_LO) + `INT3_BASE;
         o_writable = 1'b1;
      end else if (i_addr >= `FRO_LO && i_addr <= `FRO_HI) begin
         o_kind = K_FLT;
         o_idx  = 9'(i_addr - `FRO_LO) + `FRO_BASE;
      end else if (i_addr >= `FRW_LO && i_addr <= `FRW_HI) begin
         o_kind = K_FLT;
         o_idx  = 9'(i_addr - `FRW_LO) + `FRW_BASE;
         o_writable = 1'b1;
      end else if (i_addr >= `FNV_LO && i_addr <= `FNV_HI) begin
         o_kind = K_FLT;
         o_idx  = 9'(i_addr - `FNV_LO) + `FNV_BASE;
         o_writable = 1'b1;
      end else if (i_addr >= `MRO_LO && i_addr <= `MRO_HI) begin
         off    = i_addr - `MRO_LO;
         o_kind = K_MIR;
         o_idx  = 9'(off >> 1) + `FRO_BASE;
         o_hi_half = ~off[0];
      end else if (i_addr >= `MRW_LO && i_addr <= `MRW_HI) begin
         off    = i_addr - `MRW_LO;
         o_kind = K_MIR;
         o_idx  = 9'(off >> 1) + `FRW_BASE;
         o_hi_half = ~off[0];
         o_writable = 1'b1;
      end else if (i_addr >= `MNV_LO && i_addr <= `MNV_HI) begin
         off    = i_addr - `MNV_LO;
         o_kind = K_MIR;
         o_idx  = 9'(off >> 1) + `FNV_BASE;
         o_hi_half = ~off[0];
      end
   end

endmodule // regmap_addr_decode
`default_nettype wire

// *** modbus_register_map_decoder.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "regmap_params.svh"

module modbus_register_map_decoder #(
   parameter logic [31:0] RESP_CYC = 32'(`RESP_TIME_MS * `NS_PER_MS / `CLK_PERIOD_NS),
   parameter logic [31:0] SAVE_CYC = 32'(`SAVE_TIME_MS * `NS_PER_MS / `CLK_PERIOD_NS),
   parameter logic [7:0]  ID_CODE  = 8'h5a // arbitrary identifier value
) (
   input  wire logic        i_sys_clk,
   input  wire logic        i_resetn,
   input  wire logic        i_req_valid,
   output logic             o_req_ready,
   input  wire logic [7:0]  i_req_func,
   input  wire logic [15:0] i_req_addr,
   input  wire logic [15:0] i_req_count,
   input  wire logic        i_wr_valid,
   output logic             o_wr_ready,
   input  wire logic [7:0]  i_wr_byte,
   output logic             o_rd_valid,
   input  wire logic        i_rd_ready,
   output logic [7:0]       o_rd_byte,
   output logic             o_resp_valid,
   output logic [7:0]       o_resp_exc,
   input  wire logic        i_meas_we,
   input  wire logic [4:0]  i_meas_idx,
   input  wire logic [31:0] i_meas_val,
   input  wire logic        i_card_saving,
   output logic [15:0]      o_input_kind
);
   import regmap_pkg::*;

   // storage, bit 0 is the lsb of every word
   logic [15:0] int_mem [0:`INT_WORDS-1];
   logic [31:0] flt_mem [0:`FLT_WORDS-1];

   state_t      st_q, st_d;
   logic [7:0]  func_q, func_d, exc_q, exc_d, byte_q, byte_d;
   logic [15:0] base_q, base_d, cnt_q, cnt_d, cur_q, cur_d, left_q, left_d;
   logic [15:0] pend_q, pend_d, kind_q, kind_d;
   logic [8:0]  pidx_q, pidx_d;
   logic [1:0]  bi_q, bi_d;
   logic [23:0] acc_q, acc_d;
   logic [31:0] timer_q, timer_d;
   logic        fresh_q, fresh_d, fin_q, fin_d, rv_q, rv_d, id_q, id_d;
   logic        pend_v_q, pend_v_d, wrote_q, wrote_d;

   kind_t       kind;
   logic [8:0]  idx;
   logic        hi_half, writable, is_wr, bad, abort;
   logic [1:0]  be;
   logic [31:0] word, wval, lim;
   logic        c_int, c_flt, c_pair, rd_load;

   regmap_addr_decode u_dec (
      .i_addr     (cur_q),
      .o_kind     (kind),
      .o_idx      (idx),
      .o_hi_half  (hi_half),
      .o_writable (writable)
   );

   // request attributes and deadline
   assign is_wr = (func_q == `FN_WR_ONE) || (func_q == `FN_WR_GRP);
   assign lim   = i_card_saving ? SAVE_CYC : RESP_CYC;
   assign abort = (timer_q >= lim);
   assign bad   = (kind == K_NONE) || (is_wr && !writable)
                  || (func_q == `FN_WR_ONE && kind == K_FLT);
   assign be    = fresh_q ? ((kind == K_FLT && !id_q) ? 2'd3 : 2'd1) : bi_q;
   assign wval  = {acc_q, i_wr_byte};

   // word seen by the master at the current address
   always_comb begin
      word = 32'h0000_0000;
      if (id_q) begin
         word = {16'h0000, ID_CODE, `ID_RUN_STAT};
      end else if (kind == K_INT) begin
         word = {16'h0000, (idx == `KIND_SEL_IDX) ? kind_q : int_mem[idx]};
      end else if (kind == K_FLT) begin
         word = flt_mem[idx[7:0]];
      end else if (kind == K_MIR) begin
         word = hi_half ? {16'h0000, flt_mem[idx[7:0]][31:16]}
                        : {16'h0000, flt_mem[idx[7:0]][15:0]};
      end
   end

   // sequencer next state
   always_comb begin
      st_d = st_q;  func_d = func_q;  exc_d = exc_q;  byte_d = byte_q;
      base_d = base_q;  cnt_d = cnt_q;  cur_d = cur_q;  left_d = left_q;
      pend_d = pend_q;  pidx_d = pidx_q;  pend_v_d = pend_v_q;  kind_d = kind_q;
      bi_d = bi_q;  acc_d = acc_q;  timer_d = timer_q;  fresh_d = fresh_q;
      fin_d = fin_q;  rv_d = rv_q;  id_d = id_q;  wrote_d = wrote_q;
      c_int = 1'b0;  c_flt = 1'b0;  c_pair = 1'b0;  rd_load = 1'b0;
      case (st_q)
         S_IDLE: begin
            if (i_req_valid) begin
               func_d = i_req_func;
               base_d = i_req_addr;
               cur_d  = i_req_addr;
               cnt_d  = (i_req_func == `FN_WR_ONE) ? 16'h0001 : i_req_count;
               left_d = cnt_d;
               fresh_d = 1'b1;  fin_d = 1'b0;  pend_v_d = 1'b0;  wrote_d = 1'b0;
               id_d = 1'b0;  timer_d = 32'h0000_0000;  exc_d = `EXC_OK;
               if (i_req_func == `FN_RD_GRP || i_req_func == `FN_WR_GRP) begin
                  if (i_req_count == 16'h0000) begin
                     exc_d = `EXC_ILL_VAL;
                     st_d  = S_DONE;
                  end else begin
                     st_d = S_CHECK;
                  end
               end else if (i_req_func == `FN_WR_ONE) begin
                  st_d = S_CHECK;
               end else if (i_req_func == `FN_IDENT) begin
                  id_d   = 1'b1;
                  left_d = 16'h0001;
                  st_d   = S_XFER;
               end else begin
                  exc_d = `EXC_ILL_FN;
                  st_d  = S_DONE;
               end
            end
         end
         S_CHECK: begin
            // every address is vetted before anything moves
            if (abort) begin
               exc_d = `EXC_FAIL;
               st_d  = S_DONE;
            end else begin
               timer_d = timer_q + 32'h0000_0001;
               if (bad) begin
                  exc_d = `EXC_ILL_ADDR;
                  st_d  = S_DONE;
               end else if (left_q == 16'h0001) begin
                  cur_d  = base_q;
                  left_d = cnt_q;
                  st_d   = S_XFER;
               end else begin
                  cur_d  = cur_q + 16'h0001;
                  left_d = left_q - 16'h0001;
               end
            end
         end
         S_XFER: begin
            if (abort) begin
               exc_d = `EXC_FAIL;
               rv_d  = 1'b0;
               st_d  = S_DONE;
            end else begin
               timer_d = timer_q + 32'h0000_0001;
               if (is_wr) begin
                  if (i_wr_valid) begin
                     acc_d = wval[23:0];
                     if (be == 2'd0) begin
                        wrote_d = 1'b1;
                        if (kind == K_INT) begin
                           c_int = 1'b1;
                           if (idx == `KIND_SEL_IDX) begin
                              kind_d = wval[15:0];
                           end
                        end else if (kind == K_FLT) begin
                           c_flt = 1'b1;
                        end else if (hi_half) begin
                           pend_d   = wval[15:0];
                           pidx_d   = idx;
                           pend_v_d = 1'b1;
                           wrote_d  = wrote_q;
                        end else if (pend_v_q && pidx_q == idx) begin
                           c_pair   = 1'b1;
                           pend_v_d = 1'b0;
                        end else begin
                           wrote_d = wrote_q; // lone low half dropped
                        end
                     end
                     if (be == 2'd0 && left_q == 16'h0001) begin
                        st_d = S_DONE;
                     end
                  end
               end else if (!rv_q || i_rd_ready) begin
                  if (fin_q) begin
                     rv_d = 1'b0;
                     st_d = S_DONE;
                  end else begin
                     rd_load = 1'b1;
                     byte_d  = word[8*be +: 8];
                     rv_d    = 1'b1;
                     fin_d   = (be == 2'd0 && left_q == 16'h0001);
                  end
               end
               // step through bytes, then registers
               if ((is_wr && i_wr_valid) || rd_load) begin
                  if (be == 2'd0) begin
                     fresh_d = 1'b1;
                     cur_d   = cur_q + 16'h0001;
                     left_d  = left_q - 16'h0001;
                  end else begin
                     fresh_d = 1'b0;
                     bi_d    = be - 2'd1;
                  end
               end
            end
         end
         S_DONE: begin
            st_d = S_IDLE;
         end
         default: st_d = S_IDLE;
      endcase
   end

   // sequencer registers
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         st_q <= S_IDLE;  func_q <= 8'h00;  exc_q <= `EXC_OK;  byte_q <= 8'h00;
         base_q <= 16'h0000;  cnt_q <= 16'h0000;  cur_q <= 16'h0000;
         left_q <= 16'h0000;  pend_q <= 16'h0000;  kind_q <= 16'h0000;
         pidx_q <= 9'h000;  bi_q <= 2'd0;  acc_q <= 24'h000000;
         timer_q <= 32'h0000_0000;  fresh_q <= 1'b1;  fin_q <= 1'b0;
         rv_q <= 1'b0;  id_q <= 1'b0;  pend_v_q <= 1'b0;  wrote_q <= 1'b0;
      end else begin
         st_q <= st_d;  func_q <= func_d;  exc_q <= exc_d;  byte_q <= byte_d;
         base_q <= base_d;  cnt_q <= cnt_d;  cur_q <= cur_d;  left_q <= left_d;
         pend_q <= pend_d;  kind_q <= kind_d;  pidx_q <= pidx_d;  bi_q <= bi_d;
         acc_q <= acc_d;  timer_q <= timer_d;  fresh_q <= fresh_d;  fin_q <= fin_d;
         rv_q <= rv_d;  id_q <= id_d;  pend_v_q <= pend_v_d;  wrote_q <= wrote_d;
      end
   end

   // storage writes, bus and measurement side
   always_ff @(posedge i_sys_clk) begin
      if (c_int) begin
         int_mem[idx] <= wval[15:0];
      end
      if (c_flt) begin
         flt_mem[idx[7:0]] <= wval;
      end
      if (c_pair) begin
         flt_mem[idx[7:0]] <= {pend_q, wval[15:0]};
      end
      if (i_meas_we) begin
         flt_mem[{3'b000, i_meas_idx}] <= i_meas_val;
      end
   end

   // outputs
   assign o_req_ready  = (st_q == S_IDLE);
   assign o_wr_ready   = (st_q == S_XFER) && is_wr && !abort;
   assign o_rd_valid   = rv_q;
   assign o_rd_byte    = byte_q;
   assign o_resp_valid = (st_q == S_DONE);
   assign o_resp_exc   = exc_q;
   assign o_input_kind = kind_q;

   // checks
   property p_byte_desc;
      @(posedge i_sys_clk) disable iff (!i_resetn)
      (rd_load && be != 2'd0) |=> (bi_q == $past(be) - 2'd1) && !fresh_q;
   endproperty
   a_byte_desc: assert property (p_byte_desc) else $error("byte order not msb first");

   property p_msb_first;
      @(posedge i_sys_clk) disable iff (!i_resetn)
      (rd_load && fresh_q && kind == K_FLT && !id_q) |=> (o_rd_byte == $past(word[31:24]));
   endproperty
   a_msb_first: assert property (p_msb_first) else $error("float did not open with byte 3");

   property p_no_store_on_reject;
      @(posedge i_sys_clk) disable iff (!i_resetn)
      (o_resp_valid && o_resp_exc == `EXC_ILL_ADDR) |-> !wrote_q && $past(st_q) == S_CHECK;
   endproperty
   a_no_store_on_reject: assert property (p_no_store_on_reject) else $error("reject after store");

   property p_ro_float;
      @(posedge i_sys_clk) disable iff (!i_resetn)
      c_flt |-> (cur_q >= `FRW_LO) && (idx >= `FRW_BASE);
   endproperty
   a_ro_float: assert property (p_ro_float) else $error("write reached read-only float");

   property p_mirror_rw_only;
      @(posedge i_sys_clk) disable iff (!i_resetn)
      (c_pair || (is_wr && kind == K_MIR && st_q == S_XFER))
         |-> (cur_q >= `MRW_LO && cur_q <= `MRW_HI);
   endproperty
   a_mirror_rw_only: assert property (p_mirror_rw_only) else $error("read-only mirror written");

   property p_pair_whole;
      @(posedge i_sys_clk) disable iff (!i_resetn)
      c_pair |-> pend_v_q && (pidx_q == idx) && !hi_half;
   endproperty
   a_pair_whole: assert property (p_pair_whole) else $error("half pair committed");

   property p_deadline;
      @(posedge i_sys_clk) disable iff (!i_resetn)
      o_resp_valid |-> (timer_q <= lim);
   endproperty
   a_deadline: assert property (p_deadline) else $error("answer later than deadline");

   property p_int_window;
      @(posedge i_sys_clk) disable iff (!i_resetn)
      (st_q == S_CHECK && cur_q >= `INT0_LO && cur_q <= `INT0_HI)
         |-> kind == K_INT && idx == 9'(cur_q - `INT0_LO);
   endproperty
   a_int_window: assert property (p_int_window) else $error("integer window misdecoded");

   property p_bad_func;
      @(posedge i_sys_clk) disable iff (!i_resetn)
      (o_req_ready && i_req_valid && i_req_func != `FN_RD_GRP && i_req_func != `FN_WR_ONE
       && i_req_func != `FN_WR_GRP && i_req_func != `FN_IDENT)
         |=> o_resp_valid && o_resp_exc == `EXC_ILL_FN;
   endproperty
   a_bad_func: assert property (p_bad_func) else $error("unknown function not refused");

   c_read_ok:  cover property (@(posedge i_sys_clk) o_resp_valid && exc_q == `EXC_OK && !is_wr);
   c_write_ok: cover property (@(posedge i_sys_clk) c_pair);
   c_reject:   cover property (@(posedge i_sys_clk) o_resp_valid && exc_q == `EXC_ILL_ADDR);
   c_ident:    cover property (@(posedge i_sys_clk) o_resp_valid && id_q);

endmodule // modbus_register_map_decoder
`default_nettype wire

// *** bus_master_model.sv ***
`timescale 1ns/1ns
`default_nettype none

module bus_master_model (
   input  wire logic        i_sys_clk,
   input  wire logic        i_req_ready,
   input  wire logic        i_wr_ready,
   input  wire logic        i_rd_valid,
   input  wire logic [7:0]  i_rd_byte,
   input  wire logic        i_resp_valid,
   input  wire logic [7:0]  i_resp_exc,
   output logic             o_req_valid,
   output logic [7:0]       o_req_func,
   output logic [15:0]      o_req_addr,
   output logic [15:0]      o_req_count,
   output logic             o_wr_valid,
   output logic [7:0]       o_wr_byte,
   output logic             o_rd_ready
);
   logic [7:0] rd_buf [0:255];
   int         rd_n;
   logic [7:0] exc;

   // idle levels at time zero
   initial begin
      o_req_valid = 1'b0;
      o_req_func  = 8'h00;
      o_req_addr  = 16'h0000;
      o_req_count = 16'h0000;
      o_wr_valid  = 1'b0;
      o_wr_byte   = 8'h00;
      o_rd_ready  = 1'b0;
      rd_n        = 0;
      exc         = 8'h00;
   end

   // one request, entered just after a rising edge; wd is left-justified
   task automatic xfer(input logic [7:0] fn, input logic [15:0] addr,
                       input logic [15:0] cnt, input logic [63:0] wd, input int nb);
      int k;
      int guard;
      bit done;
      k = 0;
      guard = 0;
      done = 1'b0;
      rd_n = 0;
      o_req_valid = 1'b1;
      o_req_func  = fn;
      o_req_addr  = addr;
      o_req_count = cnt;
      do @(posedge i_sys_clk); while (i_req_ready !== 1'b1);
      #1;
      o_req_valid = 1'b0;
      o_req_addr  = ~addr;
      o_rd_ready  = 1'b1;
      while (!done && guard < 2000) begin
         o_wr_valid = (k < nb);
         o_wr_byte  = (k < nb) ? wd[63-8*k -: 8] : ~o_wr_byte;
         @(posedge i_sys_clk);
         if (o_wr_valid && i_wr_ready === 1'b1) k++;
         if (i_rd_valid === 1'b1) begin
            rd_buf[rd_n] = i_rd_byte;
            rd_n++;
         end
         if (i_resp_valid === 1'b1) begin
            exc  = i_resp_exc;
            done = 1'b1;
         end
         guard++;
         #1;
      end
      o_wr_valid = 1'b0;
      o_rd_ready = 1'b0;
      if (!done) exc = 8'hee;
   endtask
endmodule // bus_master_model

`default_nettype wire

// *** modbus_register_map_decoder_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "regmap_params.svh"

module modbus_register_map_decoder_bench;
   localparam logic [7:0] ID_TB = 8'h5a; // arbitrary identifier value
   // refused requests: func, addr, count, answer
   localparam logic [47:0] REFUSE [10] = '{
      {8'h06, 16'h1b58, 16'h1, `EXC_ILL_ADDR}, {8'h06, 16'h1ce8, 16'h1, `EXC_ILL_ADDR},
      {8'h10, 16'h1d4c, 16'h1, `EXC_ILL_ADDR}, {8'h06, 16'h1db0, 16'h1, `EXC_ILL_ADDR},
      {8'h03, 16'h1020, 16'h1, `EXC_ILL_ADDR}, {8'h03, 16'h129e, 16'h1, `EXC_ILL_ADDR},
      {8'h03, 16'h1d60, 16'h1, `EXC_ILL_ADDR}, {8'h03, 16'h1b7f, 16'h1, `EXC_ILL_ADDR},
      {8'h05, 16'h0fa0, 16'h1, `EXC_ILL_FN},   {8'h03, 16'h0fa0, 16'h0, `EXC_ILL_VAL}};
   logic        sys_clk = 1'b0;
   logic        resetn = 1'b0;
   logic        req_valid, req_ready, wr_valid, wr_ready, rd_valid, rd_ready, resp_valid;
   logic [7:0]  req_func, wr_byte, rd_byte, resp_exc;
   logic [15:0] req_addr, req_count, input_kind;
   logic        meas_we = 1'b0;
   logic [4:0]  meas_idx = 5'h00;
   logic [31:0] meas_val = 32'h0;
   logic        card_saving = 1'b0;
   int          failures = 0;
   int          tests_run = 0;

   always #5 sys_clk = ~sys_clk;

   modbus_register_map_decoder #(.RESP_CYC(32'd150), .SAVE_CYC(32'd600), .ID_CODE(ID_TB)) dut_u (
      .i_sys_clk(sys_clk), .i_resetn(resetn), .i_req_valid(req_valid), .o_req_ready(req_ready),
      .i_req_func(req_func), .i_req_addr(req_addr), .i_req_count(req_count),
      .i_wr_valid(wr_valid), .o_wr_ready(wr_ready), .i_wr_byte(wr_byte),
      .o_rd_valid(rd_valid), .i_rd_ready(rd_ready), .o_rd_byte(rd_byte),
      .o_resp_valid(resp_valid), .o_resp_exc(resp_exc), .i_meas_we(meas_we),
      .i_meas_idx(meas_idx), .i_meas_val(meas_val), .i_card_saving(card_saving),
      .o_input_kind(input_kind));

   bus_master_model mst_u (
      .i_sys_clk(sys_clk), .i_req_ready(req_ready), .i_wr_ready(wr_ready),
      .i_rd_valid(rd_valid), .i_rd_byte(rd_byte), .i_resp_valid(resp_valid),
      .i_resp_exc(resp_exc), .o_req_valid(req_valid), .o_req_func(req_func),
      .o_req_addr(req_addr), .o_req_count(req_count), .o_wr_valid(wr_valid),
      .o_wr_byte(wr_byte), .o_rd_ready(rd_ready));

   // value comparison
   task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // answer code comparison
   task automatic cmp_exc(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t exc got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one request and its answer code
   task automatic req(input logic [7:0] fn, input logic [15:0] addr, input logic [15:0] cnt,
                      input logic [63:0] wd, input int nb, input logic [7:0] ex);
      mst_u.xfer(fn, addr, cnt, wd, nb);
      cmp_exc(mst_u.exc, ex);
   endtask

   // read bytes against left-justified expectation
   task automatic check_rd(input logic [63:0] exp, input int nb);
      cmp_val(32'(mst_u.rd_n), 32'(nb));
      for (int i = 0; i < nb; i++) begin
         cmp_val({24'h0, mst_u.rd_buf[i]}, {24'h0, exp[63-8*i -: 8]});
      end
   endtask

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // hang guard, far beyond the expected run
   initial begin
      repeat (30000) @(posedge sys_clk);
      failures++;
      report_and_stop();
   end

   initial begin
      repeat (16) @(posedge sys_clk);
      #1;
      resetn = 1'b1;
      cmp_val({31'h0, req_ready}, 32'h1);
      cmp_val({16'h0, input_kind}, 32'h0);
      @(posedge sys_clk);
      #1;
      $display("test reset done");
      // integer registers, second address of the first window and last address of the last
      req(`FN_WR_ONE, 16'h0fa1, 16'h1, {16'h021f, 48'h0}, 2, `EXC_OK);
      req(`FN_WR_ONE, 16'h129d, 16'h1, {16'h8001, 48'h0}, 2, `EXC_OK);
      req(`FN_RD_GRP, 16'h0fa1, 16'h1, 64'h0, 0, `EXC_OK);
      check_rd({16'h021f, 48'h0}, 2);
      req(`FN_RD_GRP, 16'h129d, 16'h1, 64'h0, 0, `EXC_OK);
      check_rd({16'h8001, 48'h0}, 2);
      // adjacent windows must not alias each other
      req(`FN_WR_GRP, 16'h10e0, 16'h1, {16'h1357, 48'h0}, 2, `EXC_OK);
      req(`FN_WR_ONE, 16'h1130, 16'h1, {16'h2468, 48'h0}, 2, `EXC_OK);
      req(`FN_RD_GRP, 16'h10e0, 16'h1, 64'h0, 0, `EXC_OK);
      check_rd({16'h1357, 48'h0}, 2);
      req(`FN_RD_GRP, 16'h1130, 16'h1, 64'h0, 0, `EXC_OK);
      check_rd({16'h2468, 48'h0}, 2);
      req(`FN_WR_ONE, 16'h0fa0, 16'h1, {16'h0007, 48'h0}, 2, `EXC_OK);
      cmp_val({16'h0, input_kind}, 32'h7);
      $display("test integer done");
      // whole floats and their mirrors
      req(`FN_WR_GRP, 16'h1db0, 16'h2, 64'h41a0000043480000, 8, `EXC_OK);
      req(`FN_RD_GRP, 16'h1db0, 16'h2, 64'h0, 0, `EXC_OK);
      check_rd(64'h41a0000043480000, 8);
      req(`FN_RD_GRP, 16'h1c20, 16'h4, 64'h0, 0, `EXC_OK);
      check_rd(64'h41a0000043480000, 8);
      req(`FN_WR_GRP, 16'h1c22, 16'h2, {32'h3f800000, 32'h0}, 4, `EXC_OK);
      req(`FN_WR_ONE, 16'h1c23, 16'h1, {16'h1234, 48'h0}, 2, `EXC_OK);
      req(`FN_RD_GRP, 16'h1db1, 16'h1, 64'h0, 0, `EXC_OK);
      check_rd({32'h3f800000, 32'h0}, 4);
      req(`FN_WR_GRP, 16'h1f58, 16'h1, {32'hc1200000, 32'h0}, 4, `EXC_OK);
      req(`FN_RD_GRP, 16'h1d18, 16'h2, 64'h0, 0, `EXC_OK);
      check_rd({32'hc1200000, 32'h0}, 4);
      meas_we = 1'b1;
      meas_idx = 5'h03;
      meas_val = 32'h40490fdb;
      @(posedge sys_clk);
      #1;
      meas_we = 1'b0;
      req(`FN_RD_GRP, 16'h1d4f, 16'h1, 64'h0, 0, `EXC_OK);
      check_rd({32'h40490fdb, 32'h0}, 4);
      req(`FN_RD_GRP, 16'h1b5e, 16'h2, 64'h0, 0, `EXC_OK);
      check_rd({32'h40490fdb, 32'h0}, 4);
      $display("test float done");
      // refused requests leave storage alone
      for (int i = 0; i < 10; i++) begin
         req(REFUSE[i][47:40], REFUSE[i][39:24], REFUSE[i][23:8], 64'hdeadbeefdeadbeef, 4,
             REFUSE[i][7:0]);
      end
      req(`FN_RD_GRP, 16'h1db0, 16'h1, 64'h0, 0, `EXC_OK);
      check_rd({32'h41a00000, 32'h0}, 4);
      req(`FN_RD_GRP, 16'h1d4f, 16'h1, 64'h0, 0, `EXC_OK);
      check_rd({32'h40490fdb, 32'h0}, 4);
      $display("test refuse done");
      // identification and answer deadlines
      req(`FN_IDENT, 16'h0, 16'h0, 64'h0, 0, `EXC_OK);
      check_rd({ID_TB, `ID_RUN_STAT, 48'h0}, 2);
      req(`FN_RD_GRP, 16'h0fa0, 16'd80, 64'h0, 0, `EXC_FAIL);
      card_saving = 1'b1;
      req(`FN_RD_GRP, 16'h0fa0, 16'd80, 64'h0, 0, `EXC_OK);
      cmp_val(32'(mst_u.rd_n), 32'd160);
      $display("test ident and deadline done");
      // mid-run reset keeps float storage, clears the kind register
      resetn = 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
      cmp_val({31'h0, req_ready}, 32'h1);
      cmp_val({16'h0, input_kind}, 32'h0);
      resetn = 1'b1;
      @(posedge sys_clk);
      #1;
      req(`FN_RD_GRP, 16'h1d4f, 16'h1, 64'h0, 0, `EXC_OK);
      check_rd({32'h40490fdb, 32'h0}, 4);
      $display("test mid-run reset done");
      report_and_stop();
   end
endmodule // modbus_register_map_decoder_bench

`default_nettype wire
